// ### core/mcbo_config_core.sv
// Configuration register, link framing, strobe control and burst sequencing of the memory device.
`timescale 1ns/1ns
module mcbo_config_core (
  input  wire logic        clk_sys,        // System clock, 50 MHz.
  input  wire logic        sys_rst,        // Asynchronous reset, active high.
  input  wire logic        clkLink,        // Bus clock from the host.
  input  wire logic        csN,            // Chip select, active low.
  input  wire logic [7:0]  dqIn,           // Data bus input.
  input  wire logic        rwdsIn,         // Strobe pin input, write mask from host.
  input  wire logic        refreshReq,     // Array refresh pending, system domain.
  input  wire logic        dieStrap,       // Die identity of this die, static pin.
  output logic             rwdsOut,        // Strobe pin output level.
  output logic             rwdsOe,         // Strobe pin output enable.
  output logic      [15:0] cfgValue,       // Configuration register contents.
  output logic             deepSleep,      // Deep sleep state.
  output logic      [7:0]  impedanceOhms,  // Selected output impedance in ohms.
  output logic      [3:0]  initialLatency, // Initial latency in clocks.
  output logic             fixedLatency,   // Fixed latency mode.
  output logic             hybridBurst,    // Wrapped bursts follow hybrid order.
  output logic      [7:0]  wrapBytes,      // Wrap group size in bytes.
  output logic      [31:0] burstWordAddr,  // Word address of the current burst word.
  output logic             burstActive,    // Data phase of an array burst.
  output logic      [7:0]  burstData,      // Last data byte seen in the burst.
  output logic             burstMask       // Last write byte was masked by the host.
);

  // ---------------- System clock domain ----------------
  logic [15:0] cfg_r;
  logic [2:0]  wrTglSync_r;
  logic [2:0]  csSync_r;
  logic [15:0] wrData_r;
  logic        wrTgl_r;

  // Write events arrive as a toggle; the third stage only serves edge detection.
  wire         wrEvent    = wrTglSync_r[2] ^ wrTglSync_r[1];
  // Falling chip select while asleep is the wake event.
  wire         wakeEvent  = csSync_r[2] & ~csSync_r[1] & deepSleep;
  wire  [15:0] cfgWritten = wrEvent ? wrData_r : cfg_r;
  // wake sets power-down enable, winning over a simultaneous write of zero.
  wire  [15:0] cfgNxt     = cfgWritten | (wakeEvent ? mcbo_pkg::PD_MASK : 16'h0000);

  // Synchronisers for the link write toggle and chip select.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wrTglSync_r <= 3'h0;
      csSync_r    <= 3'h7;
    end else begin
      wrTglSync_r <= {wrTglSync_r[1:0], wrTgl_r};
      csSync_r    <= {csSync_r[1:0], csN};
    end
  end

  // register and decoded outputs reset to field defaults.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r          <= mcbo_pkg::CFG_RESET;
      cfgValue       <= mcbo_pkg::CFG_RESET;
      deepSleep      <= 1'b0;
      impedanceOhms  <= mcbo_pkg::impOhms(mcbo_pkg::CFG_RESET[mcbo_pkg::IMP_MSB:mcbo_pkg::IMP_LSB]);
      initialLatency <= mcbo_pkg::latClocks(mcbo_pkg::CFG_RESET[mcbo_pkg::LAT_MSB:mcbo_pkg::LAT_LSB]);
      fixedLatency   <= 1'b1;
      hybridBurst    <= 1'b0;
      wrapBytes      <= 8'h20;
    end else begin
      cfg_r          <= cfgNxt;
      cfgValue       <= cfgNxt;
      // zero in power-down enable means deep sleep.
      deepSleep      <= ~cfgNxt[mcbo_pkg::PD_BIT];
      impedanceOhms  <= mcbo_pkg::impOhms(cfgNxt[mcbo_pkg::IMP_MSB:mcbo_pkg::IMP_LSB]);
      initialLatency <= mcbo_pkg::latClocks(cfgNxt[mcbo_pkg::LAT_MSB:mcbo_pkg::LAT_LSB]);
      fixedLatency   <= cfgNxt[mcbo_pkg::FIXED_BIT];
      hybridBurst    <= ~cfgNxt[mcbo_pkg::HYB_BIT];
      // group size in bytes is twice the word count.
      wrapBytes      <= {1'b0, mcbo_pkg::groupMask(cfgNxt[mcbo_pkg::LEN_MSB:mcbo_pkg::LEN_LSB]), 1'b1} + 8'h01;
    end
  end

  // ---------------- Link clock domain ----------------
  // Low configuration byte, refresh request and strap cross by two flops; the byte only
  // changes between frames, so bit skew never reaches a transaction in flight.
  logic [9:0]  lnkSync1_r;
  logic [9:0]  lnkSync2_r;
  mcbo_pkg::mcbo_lnk_st_e state_r;
  logic [2:0]  byteCnt_r;
  logic [47:0] caShift_r;
  logic [4:0]  latCnt_r;
  logic        wordPhase_r;
  logic        isWrite_r;
  logic [7:0]  wrHiByte_r;

  always_ff @(posedge clkLink or posedge sys_rst) begin
    if (sys_rst) begin
      lnkSync1_r <= 10'h000;
      lnkSync2_r <= 10'h000;
    end else begin
      lnkSync1_r <= {refreshReq, dieStrap, cfg_r[7:0]};
      lnkSync2_r <= lnkSync1_r;
    end
  end

  wire  [7:0]  lnkCfg     = lnkSync2_r[7:0];
  wire         lnkDie     = lnkSync2_r[8];
  wire         lnkRefresh = lnkSync2_r[9];

  // Frame decode.
  wire  [47:0] caFull  = {caShift_r[39:0], dqIn};
  wire         caDone  = (state_r == mcbo_pkg::LS_CA) && (byteCnt_r == mcbo_pkg::CA_LAST);
  // read/write bit clear and space bit set mark a register write.
  wire         regWr   = ~caFull[mcbo_pkg::CA_RW_BIT] & caFull[mcbo_pkg::CA_SPACE_BIT];
  // fixed mode always takes the extra latency.
  // variable mode takes it only for a refresh pending when the last command byte arrives.
  wire         extraLat = lnkCfg[mcbo_pkg::FIXED_BIT] | lnkRefresh;
  wire  [3:0]  latClk   = mcbo_pkg::latClocks(lnkCfg[mcbo_pkg::LAT_MSB:mcbo_pkg::LAT_LSB]);
  wire  [4:0]  latLoad  = extraLat ? {latClk, 1'b0} : {1'b0, latClk};
  wire         dieSel   = caFull[mcbo_pkg::CA_DIE_BIT] == lnkDie;
  wire         cfgHit   = (caShift_r[31:24] == mcbo_pkg::CA_CFG_ROW) && (caShift_r[7:0] == mcbo_pkg::CA_CFG_WORD);
  wire         stepWord = (state_r == mcbo_pkg::LS_BURST) && wordPhase_r;
  wire  [31:0] startAddr = {caFull[44:16], caFull[2:0]};

  // Framing state; chip select high ends the frame asynchronously because the host
  // may stop the bus clock as soon as it deselects.
  always_ff @(posedge clkLink or posedge sys_rst or posedge csN) begin
    if (sys_rst || csN) begin
      state_r     <= mcbo_pkg::LS_CA;
      byteCnt_r   <= 3'h0;
      latCnt_r    <= 5'h00;
      wordPhase_r <= 1'b0;
      isWrite_r   <= 1'b0;
      rwdsOut     <= 1'b0;
      rwdsOe      <= 1'b0;
      burstActive <= 1'b0;
    end else begin
      unique case (state_r)
        mcbo_pkg::LS_CA: begin
          byteCnt_r <= byteCnt_r + 3'h1;
          // drive the strobe high in fixed mode, refresh level otherwise.
          rwdsOe    <= 1'b1;
          rwdsOut   <= extraLat;
          if (caDone) begin
            rwdsOut <= 1'b0;
            if (regWr) begin
              // zero latency, strobe released so nothing masks the word.
              state_r <= mcbo_pkg::LS_WRDATA;
              rwdsOe  <= 1'b0;
            end else begin
              state_r   <= mcbo_pkg::LS_LAT;
              latCnt_r  <= latLoad;
              isWrite_r <= ~caFull[mcbo_pkg::CA_RW_BIT];
              // selected die drives low, the other releases.
              rwdsOe    <= dieSel;
            end
          end
        end
        mcbo_pkg::LS_WRDATA: begin
          wordPhase_r <= ~wordPhase_r;
          if (wordPhase_r) begin
            state_r <= mcbo_pkg::LS_DONE;
          end
        end
        mcbo_pkg::LS_LAT: begin
          latCnt_r <= latCnt_r - 5'h01;
          if (latCnt_r == 5'h01) begin
            state_r     <= mcbo_pkg::LS_BURST;
            burstActive <= 1'b1;
            // The host owns the strobe as a byte mask during write data.
            if (isWrite_r) begin
              rwdsOe <= 1'b0;
            end
          end
        end
        mcbo_pkg::LS_BURST: begin
          wordPhase_r <= ~wordPhase_r;
        end
        mcbo_pkg::LS_DONE: begin
          state_r <= mcbo_pkg::LS_DONE;
        end
      endcase
    end
  end

  // Data capture that must survive the end of the frame.
  always_ff @(posedge clkLink or posedge sys_rst) begin
    if (sys_rst) begin
      caShift_r  <= 48'h0000_0000_0000;
      wrHiByte_r <= 8'h00;
      wrData_r   <= 16'h0000;
      wrTgl_r    <= 1'b0;
      burstData  <= 8'h00;
      burstMask  <= 1'b0;
    end else begin
      if ((state_r == mcbo_pkg::LS_CA) && !csN) begin
        caShift_r <= caFull;
      end
      if ((state_r == mcbo_pkg::LS_WRDATA) && !wordPhase_r) begin
        wrHiByte_r <= dqIn;
      end
      // both bytes stored; the toggle hands the word to the system domain.
      if ((state_r == mcbo_pkg::LS_WRDATA) && wordPhase_r && cfgHit) begin
        wrData_r <= {wrHiByte_r, dqIn};
        wrTgl_r  <= ~wrTgl_r;
      end
      if (state_r == mcbo_pkg::LS_BURST) begin
        burstData <= dqIn;
        burstMask <= rwdsIn & isWrite_r;
      end
    end
  end

  // burst order bit only counts for wrapped requests; linear ones ignore it.
  mcbo_burst_seq u_seq (
    .clk       (clkLink),
    .rst       (sys_rst),
    .load      (caDone),
    .step      (stepWord),
    .startAddr (startAddr),
    .linear    (caFull[mcbo_pkg::CA_TYPE_BIT]),
    .hybrid    (~lnkCfg[mcbo_pkg::HYB_BIT]),
    .lenCode   (lnkCfg[mcbo_pkg::LEN_MSB:mcbo_pkg::LEN_LSB]),
    .wordAddr  (burstWordAddr)
  );

endmodule : mcbo_config_core

// ### core/mcbo_pkg.sv
// Constants, field layout and decode functions for the configuration register and burst sequencer.
package mcbo_pkg;

  // Configuration word layout and value after reset.
  localparam logic [15:0] CFG_RESET = 16'h8F2F;
  localparam logic [15:0] PD_MASK   = 16'h8000;
  localparam int          PD_BIT    = 15;
  localparam int          IMP_MSB   = 14;
  localparam int          IMP_LSB   = 12;
  localparam int          LAT_MSB   = 7;
  localparam int          LAT_LSB   = 4;
  localparam int          FIXED_BIT = 3;
  localparam int          HYB_BIT   = 2;
  localparam int          LEN_MSB   = 1;
  localparam int          LEN_LSB   = 0;

  // Command-address word layout.
  localparam int          CA_RW_BIT    = 47;
  localparam int          CA_SPACE_BIT = 46;
  localparam int          CA_TYPE_BIT  = 45;
  localparam int          CA_DIE_BIT   = 35;
  localparam logic [2:0]  CA_LAST      = 3'h5;
  localparam logic [7:0]  CA_CFG_ROW   = 8'h01;
  localparam logic [7:0]  CA_CFG_WORD  = 8'h00;

  // Initial latency codes and their clock counts.
  localparam logic [3:0]  LAT_CODE_5 = 4'h0;
  localparam logic [3:0]  LAT_CODE_6 = 4'h1;
  localparam logic [3:0]  LAT_CODE_7 = 4'h2;
  localparam logic [3:0]  LAT_CODE_3 = 4'hE;
  localparam logic [3:0]  LAT_CODE_4 = 4'hF;
  localparam logic [3:0]  LAT_CLK_3  = 4'h3;
  localparam logic [3:0]  LAT_CLK_4  = 4'h4;
  localparam logic [3:0]  LAT_CLK_5  = 4'h5;
  localparam logic [3:0]  LAT_CLK_6  = 4'h6;
  localparam logic [3:0]  LAT_CLK_7  = 4'h7;

  // Link-side frame states.
  typedef enum logic [2:0] {LS_CA, LS_WRDATA, LS_LAT, LS_BURST, LS_DONE} mcbo_lnk_st_e;

  // Clock count for a latency code; reserved codes fall back to the default count.
  function automatic logic [3:0] latClocks(input logic [3:0] code);
    case (code)
      LAT_CODE_5: latClocks = LAT_CLK_5;
      LAT_CODE_6: latClocks = LAT_CLK_6;
      LAT_CODE_3: latClocks = LAT_CLK_3;
      LAT_CODE_4: latClocks = LAT_CLK_4;
      default:    latClocks = LAT_CLK_7;
    endcase
  endfunction : latClocks

  // Output impedance in ohms for a select code.
  function automatic logic [7:0] impOhms(input logic [2:0] code);
    case (code)
      3'h1:    impOhms = 8'h73;
      3'h2:    impOhms = 8'h43;
      3'h3:    impOhms = 8'h2E;
      3'h5:    impOhms = 8'h1B;
      3'h6:    impOhms = 8'h16;
      3'h7:    impOhms = 8'h13;
      default: impOhms = 8'h22;
    endcase
  endfunction : impOhms

  // Word-address mask of the wrap group for a burst length code.
  function automatic logic [5:0] groupMask(input logic [1:0] len);
    case (len)
      2'h0:    groupMask = 6'h3F;
      2'h1:    groupMask = 6'h1F;
      2'h2:    groupMask = 6'h07;
      default: groupMask = 6'h0F;
    endcase
  endfunction : groupMask

endpackage : mcbo_pkg

// ### core/mcbo_burst_seq.sv
// Word address sequencer for linear, legacy wrapped and hybrid bursts.
`timescale 1ns/1ns
module mcbo_burst_seq (
  input  wire logic        clk,       // Link clock.
  input  wire logic        rst,       // Asynchronous reset, active high.
  input  wire logic        load,      // Start a burst at startAddr.
  input  wire logic        step,      // Advance one word.
  input  wire logic [31:0] startAddr, // Word address from the command-address phase.
  input  wire logic        linear,    // Burst type is linear.
  input  wire logic        hybrid,    // Wrapped bursts use hybrid order.
  input  wire logic [1:0]  lenCode,   // Burst length code.
  output logic      [31:0] wordAddr   // Current word address.
);

  logic [5:0]  mask_r;
  logic [6:0]  cnt_r;
  logic        linear_r;
  logic        hybrid_r;
  logic        wrapDone_r;
  logic [31:0] nextGroup_r;

  // Group geometry derived at load time and while stepping.
  wire  [5:0]  loadMask  = mcbo_pkg::groupMask(lenCode);
  wire  [31:0] loadBase  = startAddr & ~{26'h000_0000, loadMask};
  wire  [6:0]  groupSize = {1'b0, mask_r} + 7'h01;
  wire  [31:0] addrInc   = wordAddr + 32'h0000_0001;
  wire  [31:0] wrapped   = (wordAddr & ~{26'h000_0000, mask_r}) | (addrInc & {26'h000_0000, mask_r});
  wire         goLinear  = linear_r | (hybrid_r & wrapDone_r);
  wire         jumpGroup = hybrid_r & ~wrapDone_r & (cnt_r == groupSize);

  // Settings are latched at load so a register write mid-burst cannot disturb the order.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wordAddr    <= 32'h0000_0000;
      mask_r      <= 6'h0F;
      cnt_r       <= 7'h00;
      linear_r    <= 1'b0;
      hybrid_r    <= 1'b0;
      wrapDone_r  <= 1'b0;
      nextGroup_r <= 32'h0000_0000;
    end else if (load) begin
      wordAddr    <= startAddr;
      mask_r      <= loadMask;
      cnt_r       <= 7'h01;
      linear_r    <= linear;
      hybrid_r    <= hybrid;
      wrapDone_r  <= 1'b0;
      nextGroup_r <= loadBase + {25'h000_0000, {1'b0, loadMask} + 7'h01};
    end else if (step) begin
      cnt_r <= cnt_r + 7'h01;
      if (goLinear) begin
        wordAddr <= addrInc;
      end else if (jumpGroup) begin
        wordAddr   <= nextGroup_r;
        wrapDone_r <= 1'b1;
      end else begin
        wordAddr <= wrapped;
      end
    end
  end

endmodule : mcbo_burst_seq

// ### verif/mcbo_host_model.sv
// Host controller model that frames transfers on the device link.
`timescale 1ns/1ns
module mcbo_host_model (
  input  wire logic       rwdsOut, // Strobe level from the device.
  input  wire logic       rwdsOe,  // Strobe enable from the device.
  output logic            clkLink, // Bus clock, still between frames.
  output logic            csN,     // Chip select, active low.
  output logic      [7:0] dqIn,    // Data toward the device.
  output logic            rwdsIn   // Resolved strobe wire.
);
  logic maskLvl; // Byte mask level the host shows once the device releases the strobe.
  // The device level wins while it drives; otherwise the host mask stands, low unless a test masks array data.
  assign rwdsIn = rwdsOe ? rwdsOut : maskLvl;
  // Idle bus at time zero.
  initial begin
    clkLink = 1'b0;
    csN = 1'b1;
    dqIn = 8'h00;
    maskLvl = 1'b0;
  end
  // Mask level for the data bytes of array writes, set between frames.
  task automatic setMask(input logic m);
    maskLvl = m;
  endtask : setMask
  // slow bus clock.
  // One rising edge per byte at a 32 ns period, below every latency ceiling.
  task automatic sendByte(input logic [7:0] b);
    dqIn = b;
    #8 clkLink = 1'b1;
    #16 clkLink = 1'b0;
    #8;
  endtask : sendByte
  // Edges with chip select high, used around reset.
  task automatic pulses(input int n);
    repeat (n) sendByte(dqIn);
  endtask : pulses
  // command then word.
  // Six command bytes, a data word, then moving filler; the released bus shows the inverse level.
  task automatic frame(input logic [47:0] ca, input logic [15:0] word, input int nEdges);
    csN = 1'b0;
    #8;
    for (int i = 0; i < 6; i++) sendByte(ca[47 - 8 * i -: 8]);
    for (int i = 0; i < nEdges; i++) sendByte(i == 0 ? word[15:8] : i == 1 ? word[7:0] : 8'(i) ^ 8'hA5);
    csN = 1'b1;
    dqIn = ~dqIn;
    #40;
  endtask : frame
endmodule : mcbo_host_model

// ### verif/mcbo_config_core_checker.sv
// Concurrent checks on the configuration register and link strobe.
`timescale 1ns/1ns
module mcbo_config_core_checker (
  input wire logic        clk_sys,        // System clock.
  input wire logic        sys_rst,        // Reset, active high.
  input wire logic        clkLink,        // Bus clock.
  input wire logic        csN,            // Chip select, active low.
  input wire logic [7:0]  dqIn,           // Data bus.
  input wire logic        dieStrap,       // Die identity.
  input wire logic        rwdsOut,        // Strobe level.
  input wire logic        rwdsOe,         // Strobe enable.
  input wire logic [15:0] cfgValue,       // Register contents.
  input wire logic        deepSleep,      // Deep sleep state.
  input wire logic [7:0]  impedanceOhms,  // Impedance in ohms.
  input wire logic [3:0]  initialLatency, // Latency in clocks.
  input wire logic        fixedLatency,   // Fixed latency mode.
  input wire logic [7:0]  wrapBytes,      // Wrap group bytes.
  input wire logic        burstActive     // Burst data phase.
);
  localparam logic [7:0] OHMS [8] = '{8'h22, 8'h73, 8'h43, 8'h2E, 8'h22, 8'h1B, 8'h16, 8'h13};
  localparam logic [7:0] SIZES [4] = '{8'h80, 8'h40, 8'h10, 8'h20};
  logic [7:0]  edgeCnt_r;
  logic [7:0]  firstByte_r;
  logic        dieSel_r;
  logic [15:0] cfgD1_r;
  logic [15:0] cfgD2_r;
  logic        cfgSteady;
  // Edge count inside a frame; chip select high clears it at once, as it clears the framing.
  always_ff @(posedge clkLink or posedge sys_rst or posedge csN) begin
    if (sys_rst || csN) begin
      edgeCnt_r <= 8'h00;
      firstByte_r <= 8'h00;
      dieSel_r <= 1'b0;
    end else begin
      edgeCnt_r <= (edgeCnt_r == 8'hFF) ? edgeCnt_r : edgeCnt_r + 8'h01;
      firstByte_r <= (edgeCnt_r == 8'h00) ? dqIn : firstByte_r;
      dieSel_r <= (edgeCnt_r == 8'h01) ? dqIn[3] : dieSel_r;
    end
  end
  // Decoded outputs update with the register, yet they are judged only once it has held for three edges.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfgD1_r <= mcbo_pkg::CFG_RESET;
      cfgD2_r <= mcbo_pkg::CFG_RESET;
    end else begin
      cfgD1_r <= cfgValue;
      cfgD2_r <= cfgD1_r;
    end
  end
  assign cfgSteady = (cfgValue == cfgD1_r) && (cfgD1_r == cfgD2_r);
  sequence s_array_ca_done;
    edgeCnt_r == 8'h06 && !firstByte_r[6];
  endsequence
  sequence s_read_latency_end;
    edgeCnt_r == 8'h06 + {3'h0, initialLatency, 1'h0} && fixedLatency && firstByte_r[7:6] == 2'h2;
  endsequence
  a_ca_strobe_high: assert property (@(posedge clkLink) disable iff (sys_rst || csN)
    (edgeCnt_r inside {[8'h01:8'h05]} && fixedLatency) |-> (rwdsOe && rwdsOut))
    else $error("strobe not driven high in command phase");
  a_die_strobe_release: assert property (@(posedge clkLink) disable iff (sys_rst || csN)
    s_array_ca_done |-> (rwdsOe == (dieSel_r == dieStrap)) && !rwdsOut)
    else $error("strobe wrong after command phase");
  a_reg_strobe_off: assert property (@(posedge clkLink) disable iff (sys_rst || csN)
    (edgeCnt_r == 8'h06 && firstByte_r[6]) |-> !rwdsOe)
    else $error("strobe driven during register data");
  a_fixed_latency_len: assert property (@(posedge clkLink) disable iff (sys_rst || csN)
    s_read_latency_end |-> burstActive && !$past(burstActive))
    else $error("read data not at twice the latency");
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    csN |-> !burstActive && !rwdsOe)
    else $error("activity with chip select high");
  a_sleep_enter: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(cfgValue[15]) |-> ##[0:2] deepSleep)
    else $error("deep sleep not entered");
  a_sleep_wake_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (deepSleep && $fell(csN)) |-> ##[1:8] cfgValue[15])
    else $error("enable bit not restored on wake");
  a_imp_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfgSteady |-> impedanceOhms == OHMS[cfgValue[14:12]])
    else $error("impedance decode wrong");
  a_len_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfgSteady |-> wrapBytes == SIZES[cfgValue[1:0]])
    else $error("wrap size decode wrong");
endmodule : mcbo_config_core_checker
bind mcbo_config_core mcbo_config_core_checker i_mcbo_config_core_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .clkLink(clkLink), .csN(csN), .dqIn(dqIn), .dieStrap(dieStrap),
  .rwdsOut(rwdsOut), .rwdsOe(rwdsOe), .cfgValue(cfgValue), .deepSleep(deepSleep),
  .impedanceOhms(impedanceOhms), .initialLatency(initialLatency), .fixedLatency(fixedLatency),
  .wrapBytes(wrapBytes), .burstActive(burstActive));

// ### verif/mcbo_config_core_test.sv
// Self-checking bench for the configuration register and burst order logic.
`timescale 1ns/1ns
`define CHK(g, e, m) begin totalChecks++; if ((g) !== (e)) begin failures++; $display("BAD %0t %s", $time, m); end end
module mcbo_config_core_test;
  logic        clk_sys, sys_rst, clkLink, csN, rwdsIn, refreshReq, dieStrap, rwdsOut, rwdsOe;
  logic        deepSleep, fixedLatency, hybridBurst, burstActive, burstMask;
  logic [7:0]  dqIn, impedanceOhms, wrapBytes, burstData;
  logic [3:0]  initialLatency;
  logic [15:0] cfgValue;
  logic [31:0] burstWordAddr;
  logic [31:0] seq[$];
  int          failures;
  int          totalChecks;
  mcbo_config_core i_mcbo_config_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkLink(clkLink), .csN(csN),
    .dqIn(dqIn), .rwdsIn(rwdsIn), .refreshReq(refreshReq), .dieStrap(dieStrap), .rwdsOut(rwdsOut),
    .rwdsOe(rwdsOe), .cfgValue(cfgValue), .deepSleep(deepSleep), .impedanceOhms(impedanceOhms),
    .initialLatency(initialLatency), .fixedLatency(fixedLatency), .hybridBurst(hybridBurst),
    .wrapBytes(wrapBytes), .burstWordAddr(burstWordAddr), .burstActive(burstActive),
    .burstData(burstData), .burstMask(burstMask));
  mcbo_host_model i_mcbo_host_model (.rwdsOut(rwdsOut), .rwdsOe(rwdsOe), .clkLink(clkLink), .csN(csN),
    .dqIn(dqIn), .rwdsIn(rwdsIn));
  // System clock, 20 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Record each new burst word address once the edge's updates have landed.
  always @(posedge clkLink) begin
    #2;
    if (burstActive === 1'b1 && (seq.size() == 0 || seq[$] !== burstWordAddr)) seq.push_back(burstWordAddr);
  end
  // Register write to the first configuration register, sel picks the word in register space.
  task automatic wr(input logic [15:0] v, input logic [7:0] sel);
    i_mcbo_host_model.frame({16'h6000, 8'h01, 16'h0000, sel}, v, 2);
    repeat (6) @(negedge clk_sys);
  endtask : wr
  task automatic tReset;
    `CHK(cfgValue, mcbo_pkg::CFG_RESET, "reset word")
    `CHK(deepSleep, 1'b0, "reset sleep")
    `CHK(impedanceOhms, 8'h22, "reset impedance")
    `CHK(initialLatency, 4'h7, "reset latency")
    `CHK(fixedLatency, 1'b1, "reset fixed")
    `CHK(hybridBurst, 1'b0, "reset order")
    `CHK(wrapBytes, 8'h20, "reset size")
    $display("test reset done");
  endtask : tReset
  // field tables.
  // Each row is word, ohms, clocks, bytes, hybrid; reserved bits stay ones and fixed latency stays set.
  task automatic tFields;
    logic [39:0] tab [7] = '{40'h9F0B_7352_01, 40'hAF1A_4361_01, 40'hBFE9_2E34_01, 40'hCFFC_2248_00,
                             40'hDF2D_1B74_00, 40'hEF3E_1671_00, 40'hFF2F_1372_00};
    foreach (tab[i]) begin
      wr(tab[i][39:24], 8'h00);
      `CHK(cfgValue, tab[i][39:24], "stored word")
      `CHK(impedanceOhms, tab[i][23:16], "impedance")
      `CHK(initialLatency, tab[i][15:12], "latency")
      `CHK(wrapBytes, tab[i][11:4], "wrap size")
      `CHK(hybridBurst, tab[i][0], "burst order")
    end
    wr(16'h0F00, 8'h01);
    `CHK(cfgValue, 16'hFF2F, "other register write")
    // The array write outlasts its doubled latency of 14 edges, so two masked data bytes land.
    i_mcbo_host_model.setMask(1'b1);
    i_mcbo_host_model.frame(48'h2000_0100_0000, 16'h0000, 16);
    i_mcbo_host_model.setMask(1'b0);
    repeat (6) @(negedge clk_sys);
    `CHK(cfgValue, 16'hFF2F, "array write reached register")
    `CHK(burstData, 8'hAA, "array write data")
    `CHK(burstMask, 1'b1, "array write mask")
    $display("test fields done");
  endtask : tFields
  // sleep and wake; the waking read targets the other die.
  task automatic tSleep;
    wr(16'h7F2F, 8'h00);
    `CHK(deepSleep, 1'b1, "sleep not entered")
    i_mcbo_host_model.frame(48'hA008_0000_0000, 16'h0000, 2);
    repeat (6) @(negedge clk_sys);
    `CHK(cfgValue[15], 1'b1, "enable bit not restored")
    `CHK(deepSleep, 1'b0, "still asleep")
    $display("test sleep done");
  endtask : tSleep
  // burst order from word 0x0C in a 16 byte group.
  // the group stays inside die zero.
  task automatic tBurst(input logic [15:0] cfg, input logic lin, input logic rfr);
    logic [31:0] e;
    wr(cfg, 8'h00);
    refreshReq = rfr;
    seq.delete();
    i_mcbo_host_model.frame({2'h2, lin, 29'h0000_0001, 13'h0000, 3'h4}, 16'h0000, 32);
    @(negedge clk_sys) refreshReq = 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (lin) e = 32'h0000_000C + 32'(i);
      else if (!cfg[2] && i >= 8) e = 32'h0000_0008 + 32'(i);
      else e = 32'h0000_0008 + ((32'h0000_0004 + 32'(i)) & 32'h0000_0007);
      `CHK(seq[i], e, "burst word address")
    end
    // Twice three clocks of latency leave 26 burst edges, one new word per two edges.
    `CHK(seq.size(), 14, "burst word count")
    `CHK(burstData, 8'hBA, "last burst byte")
    `CHK(burstMask, 1'b0, "read byte masked")
    $display("test burst done");
  endtask : tBurst
  // Closing counts and verdict.
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : giveVerdict
  // Watchdog sized well above the roughly ten microseconds the tests take.
  initial begin
    #200000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    giveVerdict;
  end
  // Main sequence; link edges run during and after reset so both domains see it.
  initial begin
    sys_rst = 1'b1;
    refreshReq = 1'b0;
    dieStrap = 1'b0;
    failures = 0;
    totalChecks = 0;
    fork
      i_mcbo_host_model.pulses(3);
      repeat (5) @(negedge clk_sys);
    join
    @(negedge clk_sys) sys_rst = 1'b0;
    i_mcbo_host_model.pulses(3);
    tReset;
    tFields;
    tSleep;
    tBurst(16'h8FEE, 1'b0, 1'b0);
    tBurst(16'h8FEA, 1'b0, 1'b1);
    tBurst(16'h8FEA, 1'b1, 1'b0);
    giveVerdict;
  end
endmodule : mcbo_config_core_test
